// >>> include/enc_mon_pkg.sv
// constants shared by the encoder speed and fault monitor
// assumes a 100 MHz system clock; settings arrive as plain ports
package enc_mon_pkg;
    // clock and time bases
    localparam int CLK_PERIOD_NS = 10;
    localparam int WIN_TIME_US   = 10000;  // speed sampling window
    localparam int TICK_TIME_US  = 100000; // delay timer step, 0.1 s
    localparam int WIN_CYC  = WIN_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int TICK_CYC = TICK_TIME_US * 1000 / CLK_PERIOD_NS;
    // edges*SPD_SCALE = 100*ppr*freq for a 10 ms window, 4 edges/pulse
    localparam logic [11:0] SPD_SCALE = 12'h9c4; // 2500
    localparam logic [6:0]  PCT_FULL  = 7'h64;   // 100 percent
    // setting ranges and defaults
    localparam logic [6:0] OS_LEVEL_MAX   = 7'h78; // 120 %
    localparam logic [6:0] OS_LEVEL_DEF   = 7'h73; // 115 %
    localparam logic [6:0] OS_DELAY_MAX   = 7'h14; // 2.0 s
    localparam logic [6:0] OS_DELAY_DEF   = 7'h00; // 0.0 s
    localparam logic [6:0] DEV_LEVEL_MAX  = 7'h32; // 50 %
    localparam logic [6:0] DEV_LEVEL_DEF  = 7'h0a; // 10 %
    localparam logic [6:0] DEV_DELAY_MAX  = 7'h64; // 10.0 s
    localparam logic [6:0] DEV_DELAY_DEF  = 7'h05; // 0.5 s
    localparam logic [6:0] OPEN_TIME_MAX  = 7'h64; // 10.0 s
    localparam logic [6:0] OPEN_TIME_DEF  = 7'h14; // 2.0 s
    // monitor divide setting: upper digit n, lower two digits m
    localparam logic [7:0] DIV_DIGIT   = 8'h64;    // 100
    localparam logic [7:0] DIV_DEF     = 8'h01;    // ratio 1/1
    localparam logic [5:0] DIV_M_MAX   = 6'h20;    // 32
    localparam logic [1:0] DIV_N_MAX   = 2'h1;
    // fault indices
    localparam int F_OS   = 0;
    localparam int F_DEV  = 1;
    localparam int F_OPEN = 2;
    // stopping actions
    localparam logic [1:0] ACT_DECEL = 2'h0;
    localparam logic [1:0] ACT_COAST = 2'h1;
    localparam logic [1:0] ACT_FAST  = 2'h2;
    localparam logic [1:0] ACT_ALARM = 2'h3;
endpackage : enc_mon_pkg

// >>> core/encoder_speed_fault_monitor.sv
// encoder feedback supervisor: quadrature decode, speed, faults, monitor
// assumes encoder phases already synchronous to clk; settings static
//
// Overview of operation
// - overspeed fault after level exceeded beyond delay
// - overspeed level 0..120 percent, default 115
// - overspeed delay 0..2.0 s, zero trips at once
// - deviation is |speed - reference|, timed fault
// - deviation level 0..50 percent, delay 0..10 s
// - deviation timer runs only after speed agree
// - open fault when no pulses beyond detect time
// - open check only running, ref >= 1%, not dc
// - overspeed stops drive by its action select
// - deviation stops drive by its action select
// - action 0 decel, 1 coast, 2 fast, 3 alarm
// - pulses per revolution scales the speed
// - direction select aligns phase order with forward
// - 0 means A leads forward, 1 B leads
// - monitor emits pulses scaled by (1+n)/m
// - ratio kept within 1/32 to 1, else rejected
// - monitor output only on the A/B board variant
// - supervision active only in flux vector control
`timescale 1ns/1ps
module encoder_speed_fault_monitor #(
    parameter int WIN_CYCLES  = enc_mon_pkg::WIN_CYC,  // sampling window
    parameter int TICK_CYCLES = enc_mon_pkg::TICK_CYC  // 0.1 s timer step
) (
    input  wire logic        clk,              // system clock
    input  wire logic        rst,              // sync reset, high
    input  wire logic        enc_a,            // encoder phase a
    input  wire logic        enc_b,            // encoder phase b
    input  wire logic [15:0] pulses_per_rev,   // pulses per revolution
    input  wire logic [15:0] max_output_frequency, // hz
    input  wire logic [15:0] freq_ref,         // frequency reference, hz
    input  wire logic        run,              // drive is running
    input  wire logic        dc_operation,     // dc braking active
    input  wire logic        flux_vector,      // closed loop vector mode
    input  wire logic        speed_agree,      // speed agree reached
    input  wire logic        monitor_board,    // a/b board fitted
    input  wire logic        direction_select, // 0 a leads fwd
    input  wire logic [6:0]  overspeed_level,  // percent
    input  wire logic [6:0]  overspeed_delay,  // 0.1 s units
    input  wire logic [6:0]  deviation_level,  // percent
    input  wire logic [6:0]  deviation_delay,  // 0.1 s units
    input  wire logic [6:0]  open_detect_time, // 0.1 s units
    input  wire logic [1:0]  overspeed_action, // action select
    input  wire logic [1:0]  deviation_action, // action select
    input  wire logic [1:0]  open_fault_action,// action select
    input  wire logic [7:0]  monitor_divide_setting, // n*100+m
    input  wire logic        fault_clear,      // clears latched faults
    output logic             overspeed_fault,  // latched fault
    output logic             speed_deviation_fault, // latched fault
    output logic             encoder_open_fault,    // latched fault
    output logic             stop_req,         // stop the drive
    output logic [1:0]       stop_method,      // chosen action
    output logic             alarm_only,       // alarm, keep running
    output logic [15:0]      edge_count,       // edges in last window
    output logic             motor_reverse,    // measured direction
    output logic             setting_error,    // a setting refused
    output logic             monitor_a,        // divided phase a
    output logic             monitor_a_n,      // complement
    output logic             monitor_b,        // divided phase b
    output logic             monitor_b_n       // complement
);

    // level clamp to an allowed maximum
    function automatic logic [6:0] clamp(input logic [6:0] v,
                                         input logic [6:0] mx);
        clamp = (v > mx) ? mx : v;
    endfunction : clamp

    // decode of a divide setting into n, m and its legality
    function automatic logic [8:0] div_decode(input logic [7:0] s);
        logic [7:0] n;
        logic [7:0] m;
        n = s / enc_mon_pkg::DIV_DIGIT;
        m = s % enc_mon_pkg::DIV_DIGIT;
        div_decode = {(n <= 8'(enc_mon_pkg::DIV_N_MAX)) && (m != 8'h00)
                      && (m <= 8'(enc_mon_pkg::DIV_M_MAX))
                      && (n + 8'h01 <= m),
                      n[1:0], m[5:0]};
    endfunction : div_decode

    logic        a_ff, b_ff;
    logic        a_edge, b_edge, step, up;
    logic [31:0] win_cnt_ff, tick_cnt_ff;
    logic        win_end, tick;
    logic [15:0] acc_ff;
    logic        dir_ff;
    logic [39:0] spd_s, ref_s, unit_s, os_lim, dev_lim, diff_s;
    logic [2:0]  cond, cond_ff, fault_ff;
    logic [6:0]  delay_v [3];
    logic [6:0]  tmr_ff [3];
    logic [1:0]  act_v [3];
    logic        dev_armed_ff, open_active;
    logic [8:0]  div_dec;
    logic [1:0]  div_n_ff;
    logic [5:0]  div_m_ff;
    logic [5:0]  macc_a_ff, macc_b_ff;
    logic        err_ff;
    logic        stop_ff, alarm_ff;
    logic [1:0]  meth_ff;

    // quadrature edge detect; previous samples follow the pins in reset
    // too, so no false edge appears at release
    always_ff @(posedge clk) begin
        a_ff <= enc_a;
        b_ff <= enc_b;
    end
    assign a_edge = enc_a ^ a_ff;
    assign b_edge = enc_b ^ b_ff;
    assign step   = a_edge | b_edge;
    // a leading gives a_prev == b_now on every step
    assign up = ~(a_ff ^ enc_b) ^ direction_select;

    // window and timer step dividers
    assign win_end = (win_cnt_ff == 32'(WIN_CYCLES - 1));
    assign tick    = (tick_cnt_ff == 32'(TICK_CYCLES - 1));
    always_ff @(posedge clk) begin
        if (rst || win_end) win_cnt_ff <= 32'h0;
        else win_cnt_ff <= win_cnt_ff + 32'h1;
    end
    always_ff @(posedge clk) begin
        if (rst || tick) tick_cnt_ff <= 32'h0;
        else tick_cnt_ff <= tick_cnt_ff + 32'h1;
    end

    // edges per window, saturating; direction from last step
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_ff     <= 16'h0;
            edge_count <= 16'h0;
            dir_ff     <= 1'b0;
        end else begin
            if (step) dir_ff <= ~up;
            if (win_end) begin
                edge_count <= acc_ff;
                acc_ff     <= {15'h0, step};
            end else if (step && acc_ff != 16'hffff) begin
                acc_ff <= acc_ff + 16'h1;
            end
        end
    end
    assign motor_reverse = dir_ff;

    // speed, reference and limits on the scale 100*ppr*hz
    always_comb begin
        spd_s  = 40'(edge_count) * 40'(enc_mon_pkg::SPD_SCALE);
        ref_s  = 40'(freq_ref) * 40'(pulses_per_rev)
                 * 40'(enc_mon_pkg::PCT_FULL);
        unit_s = 40'(pulses_per_rev) * 40'(max_output_frequency);
        os_lim = unit_s * 40'(clamp(overspeed_level,
                                    enc_mon_pkg::OS_LEVEL_MAX));
        dev_lim = unit_s * 40'(clamp(deviation_level,
                                     enc_mon_pkg::DEV_LEVEL_MAX));
        diff_s = (spd_s > ref_s) ? spd_s - ref_s : ref_s - spd_s;
    end

    // open check window: running, ref at least 1 %, not dc
    assign open_active = run && !dc_operation
        && (40'(freq_ref) * 40'(enc_mon_pkg::PCT_FULL)
            >= 40'(max_output_frequency));

    // deviation armed once speed agree seen during a run
    always_ff @(posedge clk) begin
        if (rst || !run || !flux_vector) dev_armed_ff <= 1'b0;
        else if (speed_agree) dev_armed_ff <= 1'b1;
    end

    // fault conditions, gated by control mode
    always_comb begin
        cond[enc_mon_pkg::F_OS]   = flux_vector
                                    && (spd_s > os_lim);
        cond[enc_mon_pkg::F_DEV]  = flux_vector && dev_armed_ff
                                    && (diff_s > dev_lim);
        cond[enc_mon_pkg::F_OPEN] = flux_vector && open_active
                                    && (edge_count == 16'h0);
    end
    always_ff @(posedge clk) begin
        if (rst) cond_ff <= 3'h0;
        else if (win_end || !flux_vector) cond_ff <= cond;
    end

    // delays and actions per fault
    assign delay_v[enc_mon_pkg::F_OS]   =
        clamp(overspeed_delay, enc_mon_pkg::OS_DELAY_MAX);
    assign delay_v[enc_mon_pkg::F_DEV]  =
        clamp(deviation_delay, enc_mon_pkg::DEV_DELAY_MAX);
    assign delay_v[enc_mon_pkg::F_OPEN] =
        clamp(open_detect_time, enc_mon_pkg::OPEN_TIME_MAX);
    assign act_v[enc_mon_pkg::F_OS]   = overspeed_action;
    assign act_v[enc_mon_pkg::F_DEV]  = deviation_action;
    assign act_v[enc_mon_pkg::F_OPEN] = open_fault_action;

    // one delay timer and sticky flag per fault; set beats clear
    for (genvar i = 0; i < 3; i++) begin : g_fault
        always_ff @(posedge clk) begin
            if (rst || !cond_ff[i]) tmr_ff[i] <= 7'h0;
            else if (tick && tmr_ff[i] != 7'h7f)
                tmr_ff[i] <= tmr_ff[i] + 7'h1;
        end
        always_ff @(posedge clk) begin
            if (rst) fault_ff[i] <= 1'b0;
            else if (cond_ff[i] && tmr_ff[i] >= delay_v[i])
                fault_ff[i] <= 1'b1;
            else if (fault_clear) fault_ff[i] <= 1'b0;
        end
    end
    assign overspeed_fault       = fault_ff[enc_mon_pkg::F_OS];
    assign speed_deviation_fault = fault_ff[enc_mon_pkg::F_DEV];
    assign encoder_open_fault    = fault_ff[enc_mon_pkg::F_OPEN];

    // stop decision: overspeed over deviation over open circuit
    always_ff @(posedge clk) begin
        if (rst) begin
            stop_ff  <= 1'b0;
            meth_ff  <= enc_mon_pkg::ACT_COAST;
            alarm_ff <= 1'b0;
        end else begin
            stop_ff  <= 1'b0;
            alarm_ff <= 1'b0;
            for (int k = 2; k >= 0; k--) begin
                if (fault_ff[k]) begin
                    if (act_v[k] == enc_mon_pkg::ACT_ALARM) begin
                        alarm_ff <= 1'b1;
                    end else begin
                        stop_ff <= 1'b1;
                        meth_ff <= act_v[k];
                    end
                end
            end
        end
    end
    assign stop_req    = stop_ff;
    assign stop_method = meth_ff;
    assign alarm_only  = alarm_ff;

    // divide setting: accept legal values only, else hold last
    assign div_dec = div_decode(monitor_divide_setting);
    always_ff @(posedge clk) begin
        if (rst) begin
            div_n_ff <= 2'(enc_mon_pkg::DIV_DEF / enc_mon_pkg::DIV_DIGIT);
            div_m_ff <= 6'(enc_mon_pkg::DIV_DEF % enc_mon_pkg::DIV_DIGIT);
            err_ff   <= 1'b0;
        end else begin
            err_ff <= !div_dec[8];
            if (div_dec[8]) begin
                div_n_ff <= div_dec[7:6];
                div_m_ff <= div_dec[5:0];
            end
        end
    end
    assign setting_error = err_ff;

    // monitor: add 1+n per phase edge, toggle output per m
    always_ff @(posedge clk) begin
        if (rst || !monitor_board) begin
            macc_a_ff <= 6'h0;
            macc_b_ff <= 6'h0;
            monitor_a <= 1'b0;
            monitor_b <= 1'b0;
        end else begin
            if (a_edge) begin
                if (macc_a_ff + 6'(div_n_ff) + 6'h1 >= div_m_ff) begin
                    macc_a_ff <= macc_a_ff + 6'(div_n_ff) + 6'h1
                                 - div_m_ff;
                    monitor_a <= ~monitor_a;
                end else macc_a_ff <= macc_a_ff + 6'(div_n_ff) + 6'h1;
            end
            if (b_edge) begin
                if (macc_b_ff + 6'(div_n_ff) + 6'h1 >= div_m_ff) begin
                    macc_b_ff <= macc_b_ff + 6'(div_n_ff) + 6'h1
                                 - div_m_ff;
                    monitor_b <= ~monitor_b;
                end else macc_b_ff <= macc_b_ff + 6'(div_n_ff) + 6'h1;
            end
        end
    end
    assign monitor_a_n = monitor_board & ~monitor_a;
    assign monitor_b_n = monitor_board & ~monitor_b;

    // checks on the fault, stop and monitor logic
    a_os_zero_delay: assert property (@(posedge clk) disable iff (rst)
        cond_ff[0] && delay_v[0] == 7'h0 |=> overspeed_fault)
        else $error("overspeed with zero delay not flagged");
    a_os_cause: assert property (@(posedge clk) disable iff (rst)
        $rose(overspeed_fault) |-> $past(cond_ff[0])
            && $past(tmr_ff[0]) >= $past(delay_v[0]))
        else $error("overspeed flagged without its condition");
    a_dev_unarmed: assert property (@(posedge clk) disable iff (rst)
        win_end && !dev_armed_ff |-> ##2 tmr_ff[1] == 7'h0)
        else $error("deviation timer ran before speed agree");
    a_open_gated: assert property (@(posedge clk) disable iff (rst)
        win_end && !open_active |-> ##2 tmr_ff[2] == 7'h0)
        else $error("open timer ran outside its window");
    a_mode_gate: assert property (@(posedge clk) disable iff (rst)
        !flux_vector [*2] |=> cond_ff == 3'h0)
        else $error("supervision active outside vector mode");
    a_os_stops: assert property (@(posedge clk) disable iff (rst)
        overspeed_fault && overspeed_action != 2'h3 |=> stop_req
            && stop_method == $past(overspeed_action))
        else $error("overspeed did not stop with its action");
    a_alarm_run: assert property (@(posedge clk) disable iff (rst)
        fault_ff != 3'h0 && overspeed_action == 2'h3
            && deviation_action == 2'h3 && open_fault_action == 2'h3
            |=> !stop_req && alarm_only)
        else $error("alarm only action stopped the drive");
    a_div_range: assert property (@(posedge clk) disable iff (rst)
        div_m_ff >= 6'(div_n_ff) + 6'h1 && div_m_ff <= 6'h20)
        else $error("monitor ratio outside 1/32 to 1");
    a_mon_absent: assert property (@(posedge clk) disable iff (rst)
        !$past(monitor_board) |-> !monitor_a && !monitor_b && !monitor_a_n)
        else $error("monitor driven without its board");
    a_dir_fwd: assert property (@(posedge clk) disable iff (rst)
        !direction_select && a_edge && !b_edge && enc_a != enc_b
            |=> !motor_reverse)
        else $error("phase a lead not taken as forward");

endmodule : encoder_speed_fault_monitor

// >>> verif/quad_encoder_model.sv
// quadrature encoder model driving phases a and b
// assumes the bench clock; steps change just after the falling edge
`timescale 1ns/1ps
module quad_encoder_model (
    input  wire logic       clk,         // bench clock
    input  wire logic [3:0] step_cycles, // cycles per step, 0 stops
    input  wire logic       b_leads,     // 1 makes phase b lead
    output logic            enc_a,       // phase a
    output logic            enc_b        // phase b
);
    logic [1:0] phase_ff; // gray position
    logic [3:0] wait_ff;  // cycles since last step
    initial begin
        phase_ff = 2'h0;
        wait_ff  = 4'h0;
    end
    // one quarter step per period; a stopped shaft holds its lines
    always @(negedge clk) begin
        if (step_cycles == 4'h0) begin
            wait_ff <= 4'h0;
        end else if (wait_ff >= step_cycles - 4'h1) begin
            wait_ff  <= 4'h0;
            phase_ff <= b_leads ? phase_ff - 2'h1 : phase_ff + 2'h1;
        end else begin
            wait_ff <= wait_ff + 4'h1;
        end
    end
    // gray decode: a changes first when counting up
    assign enc_a = phase_ff[1] ^ phase_ff[0];
    assign enc_b = phase_ff[1];
endmodule : quad_encoder_model

// >>> verif/tb_top.sv
// self-checking bench for the encoder speed and fault monitor
// assumes short window and tick parameters; speed is edges per window
`timescale 1ns/1ps
module tb_top;
    typedef struct {
        logic [3:0]  step; // encoder cycles per step
        logic [4:0]  cfg;  // b_leads, dir, flux, agree, dc
        logic [15:0] fref; // frequency reference
        logic [6:0]  lvl;  // overspeed level
        logic [1:0]  act;  // action for every fault
        logic [15:0] cnt;  // expected edges per window
        logic [3:0]  exp;  // os, dev, open, reverse
    } row_s;
    logic clk = 1'b0, rst = 1'b1, enc_a, enc_b, b_leads = 1'b0;
    logic [3:0] step = 4'h0;
    logic [15:0] freq_ref = 16'h0;
    logic run = 1'b1, dc_operation = 1'b0, flux_vector = 1'b1;
    logic speed_agree = 1'b0, monitor_board = 1'b1, direction_select = 1'b0;
    logic fault_clear = 1'b0;
    logic [6:0] overspeed_level = 7'h73, overspeed_delay = 7'h00;
    logic [1:0] overspeed_action = 2'h0, deviation_action = 2'h0;
    logic [1:0] open_fault_action = 2'h0;
    logic [15:0] pulses_per_rev = 16'h0001;
    logic [6:0] deviation_delay = 7'h02;
    logic [7:0] monitor_divide_setting = 8'h01;
    logic overspeed_fault, speed_deviation_fault, encoder_open_fault;
    logic stop_req, alarm_only, motor_reverse, setting_error;
    logic monitor_a, monitor_a_n, monitor_b, monitor_b_n;
    logic [1:0] stop_method;
    logic [15:0] edge_count;
    int n_fail = 0, n_compared = 0, cycles = 0, tog;
    logic [7:0] bad_set [3] = '{8'h65, 8'h00, 8'h21};
    // ordinary cases: one reset and 700 cycles of running each
    row_s rows [9] = '{
        '{4'h1, 5'h04, 16'h1f4, 7'h63, 2'h0, 16'h14, 4'h8},
        '{4'h1, 5'h16, 16'h1f4, 7'h64, 2'h1, 16'h14, 4'h1},
        '{4'h2, 5'h0e, 16'h1f4, 7'h73, 2'h2, 16'h0a, 4'h5},
        '{4'h2, 5'h04, 16'h1f4, 7'h73, 2'h2, 16'h0a, 4'h0},
        '{4'h0, 5'h04, 16'h0005, 7'h73, 2'h1, 16'h00, 4'h2},
        '{4'h0, 5'h04, 16'h0004, 7'h73, 2'h1, 16'h00, 4'h0},
        '{4'h0, 5'h05, 16'h1f4, 7'h73, 2'h1, 16'h00, 4'h0},
        '{4'h1, 5'h00, 16'h1f4, 7'h63, 2'h0, 16'h14, 4'h0},
        '{4'h1, 5'h04, 16'h1f4, 7'h63, 2'h3, 16'h14, 4'h8}
    };
    // clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_fail++;
            finish_test();
        end
    end
    quad_encoder_model enc (.clk(clk), .step_cycles(step),
        .b_leads(b_leads), .enc_a(enc_a), .enc_b(enc_b));
    encoder_speed_fault_monitor #(.WIN_CYCLES(20), .TICK_CYCLES(100)) uut (
        .clk(clk), .rst(rst), .enc_a(enc_a), .enc_b(enc_b),
        .pulses_per_rev(pulses_per_rev), .max_output_frequency(16'h01f4),
        .freq_ref(freq_ref), .run(run), .dc_operation(dc_operation),
        .flux_vector(flux_vector), .speed_agree(speed_agree),
        .monitor_board(monitor_board), .direction_select(direction_select),
        .overspeed_level(overspeed_level), .overspeed_delay(overspeed_delay),
        .deviation_level(7'h0a), .deviation_delay(deviation_delay),
        .open_detect_time(7'h02), .overspeed_action(overspeed_action),
        .deviation_action(deviation_action),
        .open_fault_action(open_fault_action),
        .monitor_divide_setting(monitor_divide_setting),
        .fault_clear(fault_clear), .overspeed_fault(overspeed_fault),
        .speed_deviation_fault(speed_deviation_fault),
        .encoder_open_fault(encoder_open_fault), .stop_req(stop_req),
        .stop_method(stop_method), .alarm_only(alarm_only),
        .edge_count(edge_count), .motor_reverse(motor_reverse),
        .setting_error(setting_error), .monitor_a(monitor_a),
        .monitor_a_n(monitor_a_n), .monitor_b(monitor_b),
        .monitor_b_n(monitor_b_n));
    // compare one value, report and count
    task chk(input logic [15:0] got, input logic [15:0] exp, input string s);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %0h exp %0h", $time, s, got, exp);
        end
    endtask : chk
    // count monitor_a toggles and compare against a window of values
    task chk_tog(input int lo, input int hi);
        logic prev;
        tog = 0;
        prev = monitor_a;
        repeat (400) begin
            @(negedge clk);
            if (monitor_a !== prev) tog++;
            prev = monitor_a;
        end
        n_compared++;
        if (tog < lo || tog > hi) begin
            n_fail++;
            $display("BAD %0t monitor toggles %0d", $time, tog);
        end
    endtask : chk_tog
    // reset, apply one row, let the faults settle and compare
    task run_row(input row_s r);
        logic any;
        @(negedge clk);
        rst = 1'b1;
        step = r.step;
        {b_leads, direction_select, flux_vector} = r.cfg[4:2];
        {speed_agree, dc_operation} = r.cfg[1:0];
        freq_ref = r.fref;
        overspeed_level = r.lvl;
        {overspeed_action, deviation_action, open_fault_action} = {3{r.act}};
        repeat (2) @(negedge clk);
        chk({overspeed_fault, speed_deviation_fault, encoder_open_fault}, 16'h0,
            "reset faults");
        chk({stop_req, stop_method, alarm_only}, 16'h2, "reset stop");
        chk(edge_count, 16'h0, "reset count");
        rst = 1'b0;
        repeat (700) @(negedge clk);
        any = |r.exp[3:1];
        chk(overspeed_fault, r.exp[3], "os");
        chk(speed_deviation_fault, r.exp[2], "dev");
        chk(encoder_open_fault, r.exp[1], "open");
        if (r.cfg[2]) chk(edge_count, r.cnt, "count");
        if (r.step != 4'h0) chk(motor_reverse, r.exp[0], "dir");
        chk(stop_req, any && r.act != 2'h3, "stop");
        if (any && r.act != 2'h3) chk(stop_method, r.act, "method");
        chk(alarm_only, any && r.act == 2'h3, "alarm");
    endtask : run_row
    // print counts and verdict, then end the run
    task finish_test();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    // main sequence
    initial begin
        repeat (20) @(negedge clk);
        foreach (rows[i]) run_row(rows[i]);
        // two pulses per revolution halve the speed: no overspeed now
        pulses_per_rev = 16'h0002;
        run_row('{4'h1, 5'h04, 16'h1f4, 7'h63, 2'h0, 16'h14, 4'h0});
        pulses_per_rev = 16'h0001;
        // overspeed delay of 2.0 s: quiet at 1.8 s, tripped by 2.4 s
        @(negedge clk);
        rst = 1'b1;
        overspeed_delay = 7'h14;
        @(negedge clk);
        rst = 1'b0;
        repeat (1800) @(negedge clk);
        chk(overspeed_fault, 1'b0, "os early");
        repeat (600) @(negedge clk);
        chk(overspeed_fault, 1'b1, "os late");
        // clear while the condition stands: the set wins
        fault_clear = 1'b1;
        repeat (2) @(negedge clk);
        chk(overspeed_fault, 1'b1, "set wins");
        // stop the shaft: the condition goes and the clear takes
        step = 4'h0;
        repeat (100) @(negedge clk);
        chk(overspeed_fault, 1'b0, "cleared");
        fault_clear = 1'b0;
        step = 4'h1;
        // divided monitor: a phase has 200 edges per 400 cycles
        monitor_divide_setting = 8'h02;
        chk_tog(99, 101);
        chk(monitor_a_n, {15'h0, ~monitor_a}, "compl");
        monitor_divide_setting = 8'h66;
        chk_tog(199, 201);
        monitor_divide_setting = 8'h84;
        chk_tog(11, 14);
        foreach (bad_set[i]) begin
            monitor_divide_setting = bad_set[i];
            repeat (2) @(negedge clk);
            chk(setting_error, 1'b1, "refused");
            chk_tog(11, 14);
        end
        monitor_divide_setting = 8'h02;
        repeat (2) @(negedge clk);
        chk(setting_error, 1'b0, "accepted");
        monitor_board = 1'b0;
        @(negedge clk);
        chk({monitor_a_n, monitor_b_n}, 16'h0, "no board");
        chk({monitor_a, monitor_b}, 16'h0, "no board out");
        finish_test();
    end
endmodule : tb_top
